// file: rtl/jk_flop_map.svh
// reset values and input-sync layout for the gated master-slave flop
// assumes inclusion by bare name from the flop's source files
`ifndef JK_FLOP_MAP_SVH
`define JK_FLOP_MAP_SVH

`define JKF_GATE_WIDTH 3
`define JKF_SYNC_WIDTH 9
`define JKF_POS_PULSE 8
`define JKF_POS_SET_HI 7
`define JKF_POS_SET_LO 5
`define JKF_POS_RST_HI 4
`define JKF_POS_RST_LO 2
`define JKF_POS_ASET 1
`define JKF_POS_ACLR 0
`define JKF_SYNC_RST 9'h003
`define JKF_RST_MASTER 1'h0
`define JKF_RST_SLAVE 1'h0
`define JKF_RST_Q 1'h0
`define JKF_RST_QN 1'h1
`define JKF_RST_ARMED 1'h0

`endif

// file: rtl/jk_flop_pkg.sv
// types shared by the gated master-slave flop
// assumes nothing beyond a SystemVerilog compiler
package jk_flop_pkg;

  typedef enum logic [1:0] {
    PH_LOW = 2'h1,
    PH_HIGH = 2'h2
  } phase_t;

endpackage

// file: rtl/input_sync.sv
// three-stage synchroniser with agreement filter for pin inputs
// assumes pins are asynchronous to sys_clk
`timescale 1ns/1ps
`default_nettype none
module input_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic [WIDTH-1:0] raw,
  output logic [WIDTH-1:0] stable
);

  logic [WIDTH-1:0] s1;
  logic [WIDTH-1:0] s2;
  logic [WIDTH-1:0] s3;
  logic [WIDTH-1:0] next_stable;

  // per bit: accept a change only once stages two and three agree
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++)
    begin : g_bit
      always_comb
      begin
        next_stable[i] = (s2[i] == s3[i]) ? s2[i] : stable[i];
      end
    end
  endgenerate

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      s1 <= RST_VAL;
      s2 <= RST_VAL;
      s3 <= RST_VAL;
      stable <= RST_VAL;
    end
    else
    begin
      s1 <= raw;
      s2 <= s1;
      s3 <= s2;
      stable <= next_stable;
    end
  end

endmodule // input_sync
`default_nettype wire

// file: rtl/gated_jk_master_slave_flop.sv
// gated pulse-triggered master-slave j-k flop, sampled on sys_clk
// assumes all pin inputs asynchronous; pulse clock far slower than sys_clk
//
// Overview of operation
// - Set steering is the AND of the three set gate terms, reset steering the AND of three reset terms.
// - Steering acts only after a full pulse, rising then falling; outputs never move on the rise alone.
// - While the pulse clock is low the slave is kept apart from the master.
// - On the rising pulse edge the master loads from the gated steering values.
// - While the pulse clock is high the steering inputs are ignored and the master holds.
// - On the falling pulse edge the master is copied to the slave, which drives both outputs.
// - With controls idle a full pulse holds on both-low, sets on set-only, clears on reset-only.
// - With controls idle and both steering values high each full pulse inverts both outputs.
// - Async set low forces true high and inverted low; async clear low forces the opposite.
// - Both async controls low drive both outputs high, a state not kept after release.
`timescale 1ns/1ps
`default_nettype none
`include "jk_flop_map.svh"
module gated_jk_master_slave_flop
  import jk_flop_pkg::*;
(
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic pulse_clk,
  input wire logic [`JKF_GATE_WIDTH-1:0] set_gate_term,
  input wire logic [`JKF_GATE_WIDTH-1:0] reset_gate_term,
  input wire logic async_set_n,
  input wire logic async_clear_n,
  output logic q_true,
  output logic q_inv
);

  logic [`JKF_SYNC_WIDTH-1:0] sync_out;
  logic clk_s;
  logic set_steer;
  logic reset_steer;
  logic aset_n_s;
  logic aclr_n_s;
  logic ctrl_idle;
  logic rise;
  logic fall;
  phase_t phase;
  phase_t next_phase;
  logic master;
  logic next_master;
  logic held_output_level;
  logic next_held_output_level;
  logic next_q_true;
  logic next_q_inv;
  logic clear_armed;
  logic next_clear_armed;

  // one pipeline for all pins keeps steering aligned with the pulse edge
  input_sync #(
    .WIDTH(`JKF_SYNC_WIDTH),
    .RST_VAL(`JKF_SYNC_RST)
  ) u_sync (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .raw({pulse_clk, set_gate_term, reset_gate_term, async_set_n, async_clear_n}),
    .stable(sync_out)
  );

  assign clk_s = sync_out[`JKF_POS_PULSE];
  assign set_steer = &sync_out[`JKF_POS_SET_HI:`JKF_POS_SET_LO];
  assign reset_steer = &sync_out[`JKF_POS_RST_HI:`JKF_POS_RST_LO];
  assign aset_n_s = sync_out[`JKF_POS_ASET];
  assign aclr_n_s = sync_out[`JKF_POS_ACLR];
  assign ctrl_idle = aset_n_s && aclr_n_s;

  // pulse phase tracker
  always_comb
  begin
    rise = 1'b0;
    fall = 1'b0;
    unique case (phase)
      PH_LOW:
      begin
        rise = clk_s;
        next_phase = clk_s ? PH_HIGH : PH_LOW;
      end
      PH_HIGH:
      begin
        fall = !clk_s;
        next_phase = clk_s ? PH_HIGH : PH_LOW;
      end
      default:
      begin
        next_phase = PH_LOW;
      end
    endcase
  end

  // master and slave stages
  always_comb
  begin
    next_master = master;
    next_held_output_level = held_output_level;
    if (!aset_n_s || !aclr_n_s)
    begin
      // async controls win over any pulse activity
      next_master = !aset_n_s;
      next_held_output_level = !aset_n_s;
    end
    else
    begin
      if (rise)
      begin
        unique case ({set_steer, reset_steer})
          2'h0: next_master = held_output_level;
          2'h1: next_master = 1'b0;
          2'h2: next_master = 1'b1;
          2'h3: next_master = !held_output_level;
        endcase
      end
      if (fall)
      begin
        next_held_output_level = master;
      end
    end
  end

  // outputs registered from the next slave value, both forced high while both async controls are low
  always_comb
  begin
    if (!aset_n_s && !aclr_n_s)
    begin
      next_q_true = 1'b1;
      next_q_inv = 1'b1;
    end
    else
    begin
      next_q_true = next_held_output_level;
      next_q_inv = !next_held_output_level;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      phase <= PH_LOW;
      master <= `JKF_RST_MASTER;
      held_output_level <= `JKF_RST_SLAVE;
      q_true <= `JKF_RST_Q;
      q_inv <= `JKF_RST_QN;
    end
    else
    begin
      phase <= next_phase;
      master <= next_master;
      held_output_level <= next_held_output_level;
      q_true <= next_q_true;
      q_inv <= next_q_inv;
    end
  end

  // checker helper: a clear loaded on the rise and still pending at the fall
  // pulse width is free, so a fixed-length sequence would never match
  always_comb
  begin
    next_clear_armed = clear_armed;
    if (!ctrl_idle || fall)
    begin
      next_clear_armed = 1'h0;
    end
    if (rise && ctrl_idle && !set_steer && reset_steer)
    begin
      next_clear_armed = 1'h1;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      clear_armed <= `JKF_RST_ARMED;
    end
    else
    begin
      clear_armed <= next_clear_armed;
    end
  end

  // master stays put at a rise with neither gate AND complete, so a partial gate is simply a hold
  a_gate_and_hold: assert property (@(posedge sys_clk) disable iff (!nrst)
    (rise && ctrl_idle && !(&sync_out[`JKF_POS_SET_HI:`JKF_POS_SET_LO])
      && !(&sync_out[`JKF_POS_RST_HI:`JKF_POS_RST_LO])) |=> master == $past(held_output_level))
    else $error("gated terms not ANDed into steering");

  a_rise_no_out: assert property (@(posedge sys_clk) disable iff (!nrst)
    (rise && ctrl_idle ##1 ctrl_idle) |-> q_true == $past(q_true) && q_inv == $past(q_inv))
    else $error("output moved on rising pulse edge");

  a_low_isolated: assert property (@(posedge sys_clk) disable iff (!nrst)
    (!fall && ctrl_idle) |=> held_output_level == $past(held_output_level))
    else $error("slave changed without falling edge");

  a_rise_load_set: assert property (@(posedge sys_clk) disable iff (!nrst)
    (rise && ctrl_idle && set_steer && !reset_steer) |=> master)
    else $error("master not set on rising edge");

  a_high_ignore: assert property (@(posedge sys_clk) disable iff (!nrst)
    (phase == PH_HIGH && clk_s && ctrl_idle) |=> $stable(master))
    else $error("master changed while pulse high");

  a_fall_copy: assert property (@(posedge sys_clk) disable iff (!nrst)
    (fall && ctrl_idle && aset_n_s) |=> q_true == $past(master) && q_inv == !$past(master))
    else $error("slave not loaded from master on falling edge");

  a_full_pulse_clear: assert property (@(posedge sys_clk) disable iff (!nrst)
    (fall && ctrl_idle && clear_armed) |=> !q_true && q_inv)
    else $error("full pulse with reset steering did not clear");

  a_toggle: assert property (@(posedge sys_clk) disable iff (!nrst)
    (rise && ctrl_idle && set_steer && reset_steer) |=> master != $past(held_output_level))
    else $error("master did not toggle");

  a_async_set: assert property (@(posedge sys_clk) disable iff (!nrst)
    (!aset_n_s && aclr_n_s) |=> q_true && !q_inv)
    else $error("async set did not force outputs");

  a_async_clear: assert property (@(posedge sys_clk) disable iff (!nrst)
    (aset_n_s && !aclr_n_s) |=> !q_true && q_inv)
    else $error("async clear did not force outputs");

  a_both_high: assert property (@(posedge sys_clk) disable iff (!nrst)
    (!aset_n_s && !aclr_n_s) |=> q_true && q_inv)
    else $error("both controls low without both outputs high");

  a_complement: assert property (@(posedge sys_clk) disable iff (!nrst)
    !$past(!aset_n_s && !aclr_n_s) |-> q_inv == !q_true)
    else $error("inverted output not complement of true output");

endmodule // gated_jk_master_slave_flop
`default_nettype wire

// file: testbench/jk_drive_model.sv
// model of the logic around the flop: pulse clock, steering gates, async controls
// assumes sys_clk from the bench; every change lands just after its rising edge
`timescale 1ns/1ps
`default_nettype none
`include "jk_flop_map.svh"
module jk_drive_model (
  input wire logic sys_clk,
  output logic pulse_clk,
  output logic [`JKF_GATE_WIDTH-1:0] set_gate_term,
  output logic [`JKF_GATE_WIDTH-1:0] reset_gate_term,
  output logic async_set_n,
  output logic async_clear_n
);
  // phases kept well above the design's input filter span
  localparam int PHASE = 8;
  initial
  begin
    pulse_clk = 1'h0;
    set_gate_term = '0;
    reset_gate_term = '0;
    async_set_n = 1'h1;
    async_clear_n = 1'h1;
  end
  // called between fall and rise; a call while high is a deliberate breach
  task automatic steer(input logic [`JKF_GATE_WIDTH-1:0] j, input logic [`JKF_GATE_WIDTH-1:0] k);
    set_gate_term <= j;
    reset_gate_term <= k;
    repeat (2) @(posedge sys_clk);
  endtask
  task automatic level(input logic v);
    pulse_clk <= v;
    repeat (PHASE) @(posedge sys_clk);
  endtask
  task automatic ctl(input logic s_n, input logic c_n);
    async_set_n <= s_n;
    async_clear_n <= c_n;
    repeat (PHASE) @(posedge sys_clk);
  endtask
endmodule // jk_drive_model
`default_nettype wire

// file: testbench/tb_gated_jk_master_slave_flop.sv
// self-checking bench for the gated master-slave flop
// assumes the drive model above and the design's 5-edge pin latency
`timescale 1ns/1ps
`default_nettype none
`include "jk_flop_map.svh"
module tb_gated_jk_master_slave_flop;
  logic sys_clk;
  logic nrst;
  logic pulse_clk;
  logic [`JKF_GATE_WIDTH-1:0] set_g;
  logic [`JKF_GATE_WIDTH-1:0] rst_g;
  logic a_set_n;
  logic a_clear_n;
  logic q_true;
  logic q_inv;
  logic q_exp;
  int num_errors;
  int num_checks;
  jk_drive_model drv_u (.sys_clk(sys_clk), .pulse_clk(pulse_clk), .set_gate_term(set_g),
    .reset_gate_term(rst_g), .async_set_n(a_set_n), .async_clear_n(a_clear_n));
  gated_jk_master_slave_flop dut_u (.sys_clk(sys_clk), .nrst(nrst), .pulse_clk(pulse_clk),
    .set_gate_term(set_g), .reset_gate_term(rst_g), .async_set_n(a_set_n),
    .async_clear_n(a_clear_n), .q_true(q_true), .q_inv(q_inv));
  initial
  begin
    sys_clk = 1'h0;
  end
  always #12.5 sys_clk = ~sys_clk;
  task automatic wrap_up;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // sampled mid-cycle so no edge race decides the outcome
  task automatic chk(input logic eq, input logic eqn);
    @(negedge sys_clk);
    num_checks++;
    if (q_true !== eq || q_inv !== eqn)
    begin
      num_errors++;
      $display("ERROR %0t got %h/%h exp %h/%h", $time, q_true, q_inv, eq, eqn);
    end
    @(posedge sys_clk);
  endtask
  task automatic pulse_chk(input logic [2:0] j, input logic [2:0] k, input logic flip);
    logic jj;
    logic kk;
    jj = &j;
    kk = &k;
    drv_u.steer(j, k);
    drv_u.level(1'h1);
    chk(q_exp, ~q_exp);
    if (flip)
      drv_u.steer(~j, ~k);
    drv_u.level(1'h0);
    q_exp = (jj & kk) ? ~q_exp : jj ? 1'h1 : kk ? 1'h0 : q_exp;
    chk(q_exp, ~q_exp);
  endtask
  task automatic t_steer;
    pulse_chk(3'h7, 3'h0, 1'h0);
    pulse_chk(3'h0, 3'h0, 1'h0);
    pulse_chk(3'h6, 3'h3, 1'h0);
    pulse_chk(3'h0, 3'h7, 1'h0);
    pulse_chk(3'h5, 3'h7, 1'h0);
    pulse_chk(3'h7, 3'h6, 1'h0);
    $display("test steer done");
  endtask
  task automatic t_toggle;
    repeat (3) pulse_chk(3'h7, 3'h7, 1'h0);
    pulse_chk(3'h7, 3'h7, 1'h1);
    pulse_chk(3'h7, 3'h0, 1'h1);
    $display("test toggle done");
  endtask
  task automatic t_async;
    drv_u.ctl(1'h0, 1'h1);
    chk(1'h1, 1'h0);
    drv_u.steer(3'h0, 3'h7);
    drv_u.level(1'h1);
    drv_u.level(1'h0);
    chk(1'h1, 1'h0);
    drv_u.ctl(1'h1, 1'h0);
    chk(1'h0, 1'h1);
    drv_u.ctl(1'h0, 1'h0);
    chk(1'h1, 1'h1);
    drv_u.ctl(1'h1, 1'h1);
    chk(1'h1, 1'h0);
    q_exp = 1'h1;
    pulse_chk(3'h0, 3'h7, 1'h0);
    $display("test async done");
  endtask
  initial
  begin
    num_errors = 0;
    num_checks = 0;
    q_exp = 1'h0;
    nrst = 1'h0;
    repeat (3) @(posedge sys_clk);
    nrst <= 1'h1;
    repeat (2) @(posedge sys_clk);
    chk(1'h0, 1'h1);
    t_steer();
    t_toggle();
    t_async();
    wrap_up();
  end
  // whole run is some 300 cycles
  initial
  begin
    repeat (3000) @(posedge sys_clk);
    num_errors++;
    wrap_up();
  end
endmodule // tb_gated_jk_master_slave_flop
`default_nettype wire
